// File: logic/sw2_pkg.sv
// package: constants, field layout and types of the second setup word decoder
// ****************************************************************************
// Contract
// - bit 0 flips rotation sense of commands
// - bit 1 masks origin error reporting
// - bit 2 enables analog speed limit, torque
// - codes 000 pulse+sign, 001 forward/reverse trains
// - codes 010/011/100 quadrature x1, x2, x4
// - bit 6 selects current or command speed
// - bit 7 selects motor speed or deviation
// - bit 8 torque reference limits current, speed
// - bit 9 enables torque feed-forward, speed
// - bit A level or rising-edge deviation clear
// - bit d inverts all command pulse inputs
// - bit E scales deviation monitor by hundred
// - fields latch at power reset, except 6/7
// - first monitor command speed zero in torque control
// - second monitor deviation only in position
// ****************************************************************************
package sw2_pkg;

  // setup word layout, bit 15 down to bit 0
  typedef struct packed {
    logic       rsv_f;
    logic       dev_scale;
    logic       pulse_invert;
    logic       filter_second;
    logic       rsv_b;
    logic       clear_edge;
    logic       feed_fwd;
    logic       current_limit;
    logic       mon2_sel;
    logic       mon1_sel;
    logic [2:0] pulse_mode;
    logic       speed_limit;
    logic       origin_mask;
    logic       reverse_rot;
  } sw2_setup_t;

  typedef enum logic [1:0] {
    MODE_POS    = 2'b00,
    MODE_SPEED  = 2'b01,
    MODE_TORQUE = 2'b10
  } sw2_mode_t;

  // command pulse formats
  localparam logic [2:0] FMT_PULSE_SIGN = 3'h0;
  localparam logic [2:0] FMT_FWD_REV    = 3'h1;
  localparam logic [2:0] FMT_QUAD_X1    = 3'h2;
  localparam logic [2:0] FMT_QUAD_X2    = 3'h3;
  localparam logic [2:0] FMT_QUAD_X4    = 3'h4;

  // factory value: clear on edge, forward/reverse pulse trains
  localparam logic [15:0] SETUP_FACTORY = 16'h0408;

  // register byte offsets
  localparam logic [11:0] OFS_SETUP  = 12'h000;
  localparam logic [11:0] OFS_MODE   = 12'h004;
  localparam logic [11:0] OFS_ACTIVE = 12'h008;
  localparam logic [11:0] OFS_DEV    = 12'h00c;
  localparam logic [11:0] OFS_RELOAD = 12'h010;

  localparam logic signed [15:0] DEV_ONE       = 16'sh0001;
  localparam logic signed [15:0] DEV_SCALE_DIV = 16'sh0064;
  localparam logic [15:0]        MON_ZERO      = 16'h0000;

endpackage

// File: logic/sw2_decode.sv
// module: second setup word register, command pulse decoder and monitor routing
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sw2_decode
  import sw2_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // command pulse inputs and feedback
  input  wire logic        cmd_pulse_a,
  input  wire logic        cmd_pulse_b,
  input  wire logic        clear_in,
  input  wire logic        fb_fwd,
  input  wire logic        fb_rev,
  input  wire logic        origin_error_in,
  // monitor sources
  input  wire logic [15:0] motor_current,
  input  wire logic [15:0] command_speed,
  input  wire logic [15:0] motor_speed,
  // decoded outputs
  output logic             rot_ccw_step,
  output logic             rot_cw_step,
  output logic             origin_error,
  output logic             speed_limit_en,
  output logic             current_limit_en,
  output logic             feed_fwd_en,
  output logic             filter_second,
  output logic      [15:0] first_monitor_pin,
  output logic      [15:0] second_monitor_pin
);

  // ****************************************************************************
  // register file
  // ****************************************************************************
  sw2_setup_t        setup;
  sw2_setup_t        active;
  sw2_setup_t        eff;
  sw2_mode_t         mode;
  logic signed [15:0] deviation;
  logic              reload;
  logic              a_prev;
  logic              b_prev;
  logic              clr_prev;

  sw2_setup_t        next_setup;
  sw2_setup_t        next_active;
  sw2_mode_t         next_mode;
  logic              next_reload;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              wr_en;
  logic              setup_ph;

  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pready && pwrite;

  // selects in 6/7 act at once, all else waits for reload
  always_comb
  begin
    eff          = active;
    eff.mon1_sel = setup.mon1_sel;
    eff.mon2_sel = setup.mon2_sel;
  end

  always_comb
  begin
    next_setup   = setup;
    next_mode    = mode;
    next_reload  = 1'b0;
    // reload plays the part of a power reset
    next_active  = reload ? setup : active;
    next_prdata  = 32'h0000_0000;
    next_pready  = setup_ph;
    next_pslverr = 1'b0;
    if (wr_en)
    begin
      unique case (paddr)
        OFS_SETUP:  next_setup  = sw2_setup_t'(pwdata[15:0]);
        OFS_MODE:   next_mode   = sw2_mode_t'(pwdata[1:0]);
        OFS_RELOAD: next_reload = pwdata[0];
        default:    next_reload = 1'b0;
      endcase
    end
    if (setup_ph)
    begin
      unique case (paddr)
        OFS_SETUP:  next_prdata = {16'h0000, setup};
        OFS_MODE:   next_prdata = {30'h0000_0000, mode};
        OFS_ACTIVE: next_prdata = {16'h0000, eff};
        OFS_DEV:    next_prdata = {{16{deviation[15]}}, deviation};
        OFS_RELOAD: next_prdata = 32'h0000_0000;
        default:    next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      setup   <= sw2_setup_t'(SETUP_FACTORY);
      active  <= sw2_setup_t'(SETUP_FACTORY);
      mode    <= MODE_POS;
      reload  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      setup   <= next_setup;
      active  <= next_active;
      mode    <= next_mode;
      reload  <= next_reload;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************************
  // command pulse decoding and deviation counter
  // ****************************************************************************
  logic              pa;
  logic              pb;
  logic              a_rise;
  logic              b_rise;
  logic              a_chg;
  logic              b_chg;
  logic              cmd_up;
  logic              cmd_dn;
  logic              next_ccw;
  logic              next_cw;
  logic signed [15:0] next_dev;
  logic signed [15:0] dev_mon;

  assign pa     = cmd_pulse_a ^ active.pulse_invert;
  assign pb     = cmd_pulse_b ^ active.pulse_invert;
  assign a_rise = pa && !a_prev;
  assign b_rise = pb && !b_prev;
  assign a_chg  = pa ^ a_prev;
  assign b_chg  = pb ^ b_prev;

  always_comb
  begin
    cmd_up = 1'b0;
    cmd_dn = 1'b0;
    unique case (active.pulse_mode)
      FMT_PULSE_SIGN:
      begin
        cmd_up = a_rise && !pb;
        cmd_dn = a_rise && pb;
      end
      FMT_FWD_REV:
      begin
        cmd_up = a_rise && !b_rise;
        cmd_dn = b_rise && !a_rise;
      end
      FMT_QUAD_X1:
      begin
        cmd_up = a_rise && !pb;
        cmd_dn = a_rise && pb;
      end
      FMT_QUAD_X2:
      begin
        cmd_up = a_chg && (pa ^ pb);
        cmd_dn = a_chg && !(pa ^ pb);
      end
      FMT_QUAD_X4:
      begin
        cmd_up = (a_chg && !b_chg && (pa ^ pb)) || (b_chg && !a_chg && !(pa ^ pb));
        cmd_dn = (a_chg && !b_chg && !(pa ^ pb)) || (b_chg && !a_chg && (pa ^ pb));
      end
      default:
      begin
        cmd_up = 1'b0;
        cmd_dn = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    // positive command turns counterclockwise unless reversed
    next_ccw = active.reverse_rot ? cmd_dn : cmd_up;
    next_cw  = active.reverse_rot ? cmd_up : cmd_dn;
    next_dev = deviation;
    if (cmd_up)
    begin
      next_dev = next_dev + DEV_ONE;
    end
    if (cmd_dn)
    begin
      next_dev = next_dev - DEV_ONE;
    end
    if (fb_fwd)
    begin
      next_dev = next_dev - DEV_ONE;
    end
    if (fb_rev)
    begin
      next_dev = next_dev + DEV_ONE;
    end
    // level mode clears every cycle, edge mode only on the rise
    if (clear_in && !(active.clear_edge && clr_prev))
    begin
      next_dev = 16'sh0000;
    end
  end

  assign dev_mon = active.dev_scale ? (deviation / DEV_SCALE_DIV) : deviation;

  // ****************************************************************************
  // option flags and monitor routing
  // ****************************************************************************
  logic        next_origin;
  logic        next_slim;
  logic        next_clim;
  logic        next_ffwd;
  logic [15:0] next_mon1;
  logic [15:0] next_mon2;

  always_comb
  begin
    next_origin = origin_error_in && !active.origin_mask;
    next_slim   = active.speed_limit && (mode == MODE_TORQUE);
    next_clim   = active.current_limit && (mode == MODE_SPEED);
    next_ffwd   = active.feed_fwd && (mode == MODE_SPEED);
    next_mon1   = motor_current;
    if (eff.mon1_sel)
    begin
      next_mon1 = (mode == MODE_TORQUE) ? MON_ZERO : command_speed;
    end
    next_mon2 = motor_speed;
    if (eff.mon2_sel)
    begin
      next_mon2 = (mode == MODE_POS) ? dev_mon : MON_ZERO;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      a_prev             <= 1'b0;
      b_prev             <= 1'b0;
      clr_prev           <= 1'b0;
      deviation          <= 16'sh0000;
      rot_ccw_step       <= 1'b0;
      rot_cw_step        <= 1'b0;
      origin_error       <= 1'b0;
      speed_limit_en     <= 1'b0;
      current_limit_en   <= 1'b0;
      feed_fwd_en        <= 1'b0;
      filter_second      <= 1'b0;
      first_monitor_pin  <= MON_ZERO;
      second_monitor_pin <= MON_ZERO;
    end
    else
    begin
      a_prev             <= pa;
      b_prev             <= pb;
      clr_prev           <= clear_in;
      deviation          <= next_dev;
      rot_ccw_step       <= next_ccw;
      rot_cw_step        <= next_cw;
      origin_error       <= next_origin;
      speed_limit_en     <= next_slim;
      current_limit_en   <= next_clim;
      feed_fwd_en        <= next_ffwd;
      filter_second      <= active.filter_second;
      first_monitor_pin  <= next_mon1;
      second_monitor_pin <= next_mon2;
    end
  end

  // ****************************************************************************
  // assertions
  // ****************************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_MON1_TORQUE_ZERO: assert property (
    (mode == MODE_TORQUE && setup.mon1_sel) |=> first_monitor_pin == MON_ZERO)
    else $error("first monitor not zero in torque control");
  AST_MON1_CURRENT: assert property (
    !setup.mon1_sel |=> first_monitor_pin == $past(motor_current))
    else $error("first monitor does not carry current");
  AST_MON2_DEV_ONLY_POS: assert property (
    (mode != MODE_POS && setup.mon2_sel) |=> second_monitor_pin == MON_ZERO)
    else $error("second monitor not zero outside position control");
  AST_MON2_SPEED: assert property (
    !setup.mon2_sel |=> second_monitor_pin == $past(motor_speed))
    else $error("second monitor does not carry speed");
  AST_ORIGIN_MASKED: assert property (
    active.origin_mask |=> !origin_error)
    else $error("origin error reported while masked");
  AST_LEVEL_CLEAR: assert property (
    (!active.clear_edge && clear_in) [*2] |=> deviation == 16'sh0000)
    else $error("deviation not held clear by level");
  AST_BAD_CODE_SILENT: assert property (
    active.pulse_mode > FMT_QUAD_X4 |=> !rot_ccw_step && !rot_cw_step)
    else $error("undefined pulse code produced a count");
  AST_LATCH_HOLD: assert property (
    !reload |=> $stable(active))
    else $error("latched fields changed without reload");
  AST_LATCH_LOAD: assert property (
    reload |=> active == $past(setup))
    else $error("reload did not take the written word");
  AST_FWD_PULSE: assert property (
    (active.pulse_mode == FMT_FWD_REV && a_rise && !b_rise && !active.reverse_rot)
      |=> rot_ccw_step && !rot_cw_step)
    else $error("forward pulse did not step counterclockwise");
  AST_APB_ANSWER: assert property (
    setup_ph |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

  COV_QUAD_X4: cover property (active.pulse_mode == FMT_QUAD_X4 ##1 rot_ccw_step);
  COV_EDGE_CLEAR: cover property (active.clear_edge && clear_in && !clr_prev);
  COV_RELOAD: cover property (reload ##1 active != $past(active));
  COV_DEV_MON: cover property (mode == MODE_POS && setup.mon2_sel && active.dev_scale);

endmodule

`default_nettype wire

// File: bench/sw2_pulse_host.sv
// model: host position controller issuing command pulses
`timescale 1ns/1ps
`default_nettype none

module sw2_pulse_host
  import sw2_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // format the host follows and its pulse lines
  input  wire logic [2:0] fmt,
  output var  logic       pulse_a,
  output var  logic       pulse_b
);
  // ****************************************************************
  // one command unit per call
  // ****************************************************************
  logic [1:0] phase;

  initial
  begin
    phase = 2'h0;
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end

  task automatic step(input logic up);
    if (fmt >= FMT_QUAD_X1)
    begin
      // one gray state per call, four calls make a full cycle
      phase = up ? phase + 2'h1 : phase - 2'h1;
      @(posedge sys_clk);
      pulse_a <= phase[1] ^ phase[0];
      pulse_b <= phase[1];
      @(posedge sys_clk);
    end
    else
    begin
      // sign settles a cycle before the pulse edge
      @(posedge sys_clk);
      pulse_b <= (fmt == FMT_PULSE_SIGN) && !up;
      @(posedge sys_clk);
      pulse_a <= (fmt == FMT_PULSE_SIGN) || up;
      pulse_b <= !up;
      @(posedge sys_clk);
      pulse_a <= 1'b0;
      pulse_b <= (fmt == FMT_PULSE_SIGN) && !up;
    end
  endtask

endmodule

`default_nettype wire

// File: bench/sw2_decode_tb_top.sv
// bench: register access, pulse decoding and monitor routing tests
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
  begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sw2_decode_tb_top;
  import sw2_pkg::*;

  // ****************************************************************
  // stimulus, design and host model
  // ****************************************************************
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, clear_in = 1'b0, origin_error_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, pa, pb, counterclockwise, cw, oerr, slim, clim, ffe, filt;
  logic [15:0] mcur = 16'h1111, cspd = 16'h2222, mspd = 16'h3333, mon1, mon2;
  logic [2:0]  fmt = 3'h0;
  int          miscompares = 0, checked = 0, ccw_n = 0, cw_n = 0;
  int          exp_n[8] = '{4, 4, 1, 2, 4, 0, 0, 0};
  sw2_setup_t  s;

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    ccw_n += (counterclockwise === 1'b1);
    cw_n += (cw === 1'b1);
  end

  sw2_decode sw2_decode_inst (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_pulse_a(pa), .cmd_pulse_b(pb),
    .clear_in(clear_in), .fb_fwd(1'b0), .fb_rev(1'b0),
    .origin_error_in(origin_error_in), .motor_current(mcur),
    .command_speed(cspd), .motor_speed(mspd), .rot_ccw_step(counterclockwise),
    .rot_cw_step(cw), .origin_error(oerr), .speed_limit_en(slim),
    .current_limit_en(clim), .feed_fwd_en(ffe), .filter_second(filt),
    .first_monitor_pin(mon1), .second_monitor_pin(mon2));

  sw2_pulse_host sw2_pulse_host_inst (.sys_clk(sys_clk), .fmt(fmt), .pulse_a(pa), .pulse_b(pb));

  // ****************************************************************
  // access tasks and verdict
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // written words keep bits b and F at zero
  task automatic cfg(input logic [15:0] w);
    apb(1'b1, OFS_SETUP, {16'h0, w});
    apb(1'b1, OFS_RELOAD, 32'h1);
    repeat (4) @(posedge sys_clk);
    fmt = w[5:3];
    ccw_n = 0;
    cw_n = 0;
  endtask

  task automatic steps(input int n);
    repeat (n) sw2_pulse_host_inst.step(1'b1);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, OFS_SETUP, 32'h0);
    `CHK(rdat, 32'h0000_0408)
    apb(1'b0, OFS_ACTIVE, 32'h0);
    `CHK(rdat, 32'h0000_0408)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    for (int f = 0; f < 8; f++)
    begin
      s = SETUP_FACTORY;
      s.pulse_mode = f[2:0];
      cfg(s);
      steps(4);
      `CHK(ccw_n, exp_n[f])
    end
    // back to a defined format before the unlatched write
    cfg(SETUP_FACTORY);
    s = SETUP_FACTORY;
    s.reverse_rot = 1'b1;
    s.filter_second = 1'b1;
    apb(1'b1, OFS_SETUP, {16'h0, s});
    steps(1);
    `CHK(ccw_n, 1)
    `CHK(filt, 1'b0)
    cfg(s);
    steps(1);
    `CHK(cw_n, 1)
    `CHK(filt, 1'b1)
    s = SETUP_FACTORY;
    s.pulse_mode = FMT_PULSE_SIGN;
    s.pulse_invert = 1'b1;
    cfg(s);
    steps(1);
    `CHK(cw_n, 1)
    s = SETUP_FACTORY;
    cfg(s);
    origin_error_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(oerr, 1'b1)
    s.origin_mask = 1'b1;
    s.speed_limit = 1'b1;
    s.current_limit = 1'b1;
    s.feed_fwd = 1'b1;
    cfg(s);
    apb(1'b1, OFS_MODE, 32'h2);
    repeat (3) @(posedge sys_clk);
    `CHK({oerr, slim, clim, ffe}, 4'b0100)
    apb(1'b1, OFS_MODE, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK({oerr, slim, clim, ffe}, 4'b0011)
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_SETUP, {16'h0, SETUP_FACTORY});
    repeat (3) @(posedge sys_clk);
    `CHK({mon1, mon2}, {mcur, mspd})
    clear_in <= 1'b1;
    steps(3);
    s = SETUP_FACTORY;
    s.mon1_sel = 1'b1;
    s.mon2_sel = 1'b1;
    apb(1'b1, OFS_SETUP, {16'h0, s});
    repeat (3) @(posedge sys_clk);
    `CHK({mon1, mon2}, {cspd, 16'h0003})
    apb(1'b1, OFS_MODE, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK({mon1, mon2}, {cspd, MON_ZERO})
    apb(1'b1, OFS_MODE, 32'h2);
    repeat (3) @(posedge sys_clk);
    `CHK({mon1, mon2}, {MON_ZERO, MON_ZERO})
    apb(1'b1, OFS_MODE, 32'h0);
    s.clear_edge = 1'b0;
    cfg(s);
    steps(3);
    `CHK(mon2, MON_ZERO)
    clear_in <= 1'b0;
    s.clear_edge = 1'b1;
    s.dev_scale = 1'b1;
    cfg(s);
    steps(250);
    `CHK(mon2, 16'h0002)
    apb(1'b0, OFS_DEV, 32'h0);
    `CHK(rdat, 32'h0000_00fa)
    report_and_stop();
  end

endmodule

`default_nettype wire
